// ---- common/core_alu_if.sv ----
/*
  Operand and result bundle between the core sequencer and its ALU.
  Assumes a purely combinational ALU on the far side.
*/
`timescale 1ns/10ps
interface core_alu_if;
  core_datapath_pkg::aluOp_t op;
  logic [7:0] fileVal;
  logic [7:0] wVal;
  logic carryIn;
  logic [2:0] bitSel;
  logic [7:0] result;
  logic carryOut;
  logic digitOut;
  logic zeroOut;
  modport core (output op, fileVal, wVal, carryIn, bitSel,
                input result, carryOut, digitOut, zeroOut);
  modport alu (input op, fileVal, wVal, carryIn, bitSel,
               output result, carryOut, digitOut, zeroOut);
endinterface : core_alu_if

// ---- common/core_datapath_cfg.svh ----
/*
  Address map, field positions, reset values and sizes of the bank-0 core.
  Assumes inclusion by bare name from the core module only.
*/
`ifndef CORE_DATAPATH_CFG_SVH
`define CORE_DATAPATH_CFG_SVH

// ----------------------------------------------------------------------
// Bank-0 file addresses
// ----------------------------------------------------------------------
`define ADDR_INDIRECT_PORT 7'h00
`define ADDR_TIMER_COUNT 7'h01
`define ADDR_PC_LOW_BYTE 7'h02
`define ADDR_ARITH_STATUS 7'h03
`define ADDR_INDIRECT_POINTER 7'h04
`define ADDR_PORT_A_PINS 7'h05
`define ADDR_PORT_B_PINS 7'h06
`define ADDR_PC_HIGH_LATCH 7'h0a
`define ADDR_INTERRUPT_CONTROL 7'h0b
`define ADDR_PERIPH_INT_FLAGS 7'h0c
`define ADDR_GPR_FIRST 7'h20
`define ADDR_GPR_LAST 7'h6f

// ----------------------------------------------------------------------
// Status field positions and flag masks {zero, nibble carry, carry}
// ----------------------------------------------------------------------
`define ST_CARRY 0
`define ST_NIBBLE_CARRY 1
`define ST_ZERO 2
`define ST_POWER_DOWN 3
`define ST_TIME_OUT 4
`define ST_BANK_SELECT 5
`define FLAGS_NONE 3'h0
`define FLAGS_Z 3'h4
`define FLAGS_C 3'h1
`define FLAGS_CDZ 3'h7
`define INTCTL_GLOBAL_EN 7
`define PIR_CMP_FLAG 6

// ----------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------
`define RST_STATUS 8'h18
`define RST_PC 13'h0000
`define RST_PC_HIGH_LATCH 5'h00
`define RST_BYTE 8'h00
`define PROG_WORDS 512
`define GPR_WORDS 80
`define STACK_DEPTH 8
`define INSTR_LAST_BIT 4'hd

// ----------------------------------------------------------------------
// Fixed miscellaneous opcodes (class 00, sub-op 0000, d = 0)
// ----------------------------------------------------------------------
`define OP_RETURN 7'h08
`define OP_RETFIE 7'h09
`define OP_SLEEP 7'h63
`define OP_CLRWDT 7'h64

`endif

// ---- common/core_datapath_pkg.sv ----
/*
  Types shared by the core and its ALU.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package core_datapath_pkg;

  // ALU operation selector
  typedef enum logic [3:0] {
    ALU_ADD = 4'h0, ALU_SUB = 4'h1, ALU_AND = 4'h2, ALU_IOR = 4'h3,
    ALU_XOR = 4'h4, ALU_PASSF = 4'h5, ALU_PASSW = 4'h6, ALU_COM = 4'h7,
    ALU_INC = 4'h8, ALU_DEC = 4'h9, ALU_RRF = 4'ha, ALU_RLF = 4'hb,
    ALU_SWAP = 4'hc, ALU_CLR = 4'hd, ALU_BCLR = 4'he, ALU_BSET = 4'hf
  } aluOp_t;

  // Core operating mode, one-hot
  typedef enum logic [1:0] {
    MODE_RUN = 2'b01,
    MODE_PROG = 2'b10
  } coreMode_t;

endpackage : core_datapath_pkg

// ---- hdl/core_alu.sv ----
/*
  8-bit two's complement ALU with carry, nibble carry and zero outputs.
  Assumes the core decides which flags are actually stored.
*/
`timescale 1ns/10ps
module core_alu (
  core_alu_if.alu bus // Operands in, result and flags out
);

  // ----------------------------------------------------------------------
  // Datapath
  // ----------------------------------------------------------------------
  // Single case keeps every output assigned on every path
  always_comb
  begin
    logic [8:0] sum;
    logic [4:0] nib;
    sum = 9'h000;
    nib = 5'h00;
    bus.result = bus.fileVal;
    bus.carryOut = bus.carryIn;
    bus.digitOut = 1'b0;
    case (bus.op)
      core_datapath_pkg::ALU_ADD:
      begin
        sum = {1'b0, bus.fileVal} + {1'b0, bus.wVal};
        nib = {1'b0, bus.fileVal[3:0]} + {1'b0, bus.wVal[3:0]};
        bus.result = sum[7:0];
        bus.carryOut = sum[8];
        bus.digitOut = nib[4];
      end
      core_datapath_pkg::ALU_SUB:
      begin
        // Carry reads as not-borrow, so it is the inverted borrow
        sum = {1'b0, bus.fileVal} - {1'b0, bus.wVal};
        nib = {1'b0, bus.fileVal[3:0]} - {1'b0, bus.wVal[3:0]};
        bus.result = sum[7:0];
        bus.carryOut = ~sum[8];
        bus.digitOut = ~nib[4];
      end
      core_datapath_pkg::ALU_AND: bus.result = bus.fileVal & bus.wVal;
      core_datapath_pkg::ALU_IOR: bus.result = bus.fileVal | bus.wVal;
      core_datapath_pkg::ALU_XOR: bus.result = bus.fileVal ^ bus.wVal;
      core_datapath_pkg::ALU_PASSW: bus.result = bus.wVal;
      core_datapath_pkg::ALU_COM: bus.result = ~bus.fileVal;
      core_datapath_pkg::ALU_INC: bus.result = bus.fileVal + 8'h01;
      core_datapath_pkg::ALU_DEC: bus.result = bus.fileVal - 8'h01;
      core_datapath_pkg::ALU_RRF:
      begin
        bus.result = {bus.carryIn, bus.fileVal[7:1]};
        bus.carryOut = bus.fileVal[0];
      end
      core_datapath_pkg::ALU_RLF:
      begin
        bus.result = {bus.fileVal[6:0], bus.carryIn};
        bus.carryOut = bus.fileVal[7];
      end
      core_datapath_pkg::ALU_SWAP: bus.result = {bus.fileVal[3:0], bus.fileVal[7:4]};
      core_datapath_pkg::ALU_CLR: bus.result = 8'h00;
      core_datapath_pkg::ALU_BCLR: bus.result = bus.fileVal & ~(8'h01 << bus.bitSel);
      core_datapath_pkg::ALU_BSET: bus.result = bus.fileVal | (8'h01 << bus.bitSel);
      default: bus.result = bus.fileVal;
    endcase
  end

  assign bus.zeroOut = (bus.result == 8'h00);

endmodule : core_alu

// ---- hdl/core_datapath_sfr_bank0.sv ----
/*
  Two-stage 14-bit instruction core with accumulator, bank-0 core special
  registers, indirect addressing, on-chip program store and serial loader.
  Assumes all inputs synchronous to clk_sys; one instruction per clock.
*/
// Functional notes
// - Separate program and data stores and paths
// - Instructions are single 14-bit words
// - Fetch next while current one executes
// - Every instruction one cycle except branches
// - On-chip program store of 512 words
// - Special registers live in data space
// - 8-bit ALU: add, subtract, shift, logic
// - Operands: accumulator with file or literal
// - Accumulator has no data address
// - ALU updates carry, nibble carry, zero
// - Subtract carries mean borrow-out inverted
// - Special registers are plain storage cells; here port addresses read the pins and status bits 3-4 ignore writes
// - Address zero accesses pointer-selected location
// - Serial loader: port B clock, data
// - Pointer at zero: read zero, write none
`timescale 1ns/10ps
`include "core_datapath_cfg.svh"
module core_datapath_sfr_bank0 (
  input wire logic clk_sys, // Core clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic clkEn, // Freezes all state while low
  input wire logic progMode, // High holds the core and enables the loader
  input wire logic [4:0] portAIn, // Port A pin levels
  input wire logic [7:0] portBIn, // Port B pin levels, bits 6/7 load
  output logic [4:0] portAOut, // Port A output latch
  output logic [7:0] portBOut, // Port B output latch
  output logic [7:0] accOut, // Accumulator
  output logic [12:0] pcOut // Next fetch address
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [13:0] progStore [0:`PROG_WORDS-1];
  logic [7:0] gpr [0:`GPR_WORDS-1];
  logic [12:0] callStack [0:`STACK_DEPTH-1];
  core_datapath_pkg::coreMode_t mode, next_mode;
  logic [12:0] pc, next_pc;
  logic [13:0] ir, next_ir;
  logic irValid, next_irValid;
  logic [7:0] w, next_w;
  logic [7:0] status, next_status;
  logic [7:0] indirect_pointer, next_fsr;
  logic [4:0] pc_high_latch, next_pc_high_latch;
  logic [7:0] timer, next_timer;
  logic [4:0] portALat, next_portALat;
  logic [7:0] portBLat, next_portBLat;
  logic [7:0] intCtl, next_intCtl;
  logic pirCmp, next_pirCmp;
  logic [2:0] sp, next_sp;
  logic [13:0] progShift, next_progShift;
  logic [3:0] progCnt, next_progCnt;
  logic [8:0] progAddr, next_progAddr;
  logic progClkPrev;
  logic pmWe;
  logic gprWe;
  logic stackWe;
  logic [6:0] ea;
  logic selfRef;
  logic [7:0] fileRd;
  logic wrFile;
  logic wrW;
  logic [2:0] flagMask;
  logic progClkRise;

  core_alu_if aluBus ();

  core_alu aluInst (
    .bus(aluBus)
  );

  // ----------------------------------------------------------------------
  // Effective address and file read
  // ----------------------------------------------------------------------
  // Address zero redirects through the pointer; bank bit picks bank 1
  always_comb
  begin
    if (ir[6:0] == `ADDR_INDIRECT_PORT)
    begin
      ea = indirect_pointer[6:0];
      selfRef = (indirect_pointer[6:0] == `ADDR_INDIRECT_PORT) || indirect_pointer[7];
    end
    else
    begin
      ea = ir[6:0];
      selfRef = status[`ST_BANK_SELECT];
    end
  end

  // Data-space read mux; bank 1 and holes read as zero
  always_comb
  begin
    fileRd = 8'h00;
    if (!selfRef)
    begin
      case (ea)
        `ADDR_TIMER_COUNT: fileRd = timer;
        `ADDR_PC_LOW_BYTE: fileRd = pc[7:0];
        `ADDR_ARITH_STATUS: fileRd = status;
        `ADDR_INDIRECT_POINTER: fileRd = indirect_pointer;
        `ADDR_PORT_A_PINS: fileRd = {3'h0, portAIn};
        `ADDR_PORT_B_PINS: fileRd = portBIn;
        `ADDR_PC_HIGH_LATCH: fileRd = {3'h0, pc_high_latch};
        `ADDR_INTERRUPT_CONTROL: fileRd = intCtl;
        `ADDR_PERIPH_INT_FLAGS: fileRd = {1'b0, pirCmp, 6'h00};
        default:
        begin
          // Accumulator is deliberately absent from this map
          if (ea >= `ADDR_GPR_FIRST && ea <= `ADDR_GPR_LAST)
            fileRd = gpr[7'(ea - `ADDR_GPR_FIRST)];
        end
      endcase
    end
  end

  assign progClkRise = portBIn[6] & ~progClkPrev;

  // ----------------------------------------------------------------------
  // Decode, execute and next-state computation
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_mode = mode;
    next_pc = pc;
    next_ir = ir;
    next_irValid = irValid;
    next_w = w;
    next_status = status;
    next_fsr = indirect_pointer;
    next_pc_high_latch = pc_high_latch;
    next_timer = timer;
    next_portALat = portALat;
    next_portBLat = portBLat;
    next_intCtl = intCtl;
    next_pirCmp = pirCmp;
    next_sp = sp;
    next_progShift = progShift;
    next_progCnt = progCnt;
    next_progAddr = progAddr;
    pmWe = 1'b0;
    gprWe = 1'b0;
    stackWe = 1'b0;
    wrFile = 1'b0;
    wrW = 1'b0;
    flagMask = `FLAGS_NONE;
    aluBus.op = core_datapath_pkg::ALU_PASSF;
    // Literal class takes its operand from the instruction word
    aluBus.fileVal = (ir[13:12] == 2'b11) ? ir[7:0] : fileRd;
    aluBus.wVal = w;
    aluBus.carryIn = status[`ST_CARRY];
    aluBus.bitSel = ir[9:7];
    if (mode == core_datapath_pkg::MODE_PROG)
    begin
      // Loader: LSB first, one word per 14 rising clock edges
      if (progClkRise)
      begin
        next_progShift = {portBIn[7], progShift[13:1]};
        next_progCnt = progCnt + 4'h1;
        if (progCnt == `INSTR_LAST_BIT)
        begin
          pmWe = 1'b1;
          next_progCnt = 4'h0;
          next_progAddr = progAddr + 9'h001;
        end
      end
      if (!progMode)
      begin
        next_mode = core_datapath_pkg::MODE_RUN;
        next_pc = `RST_PC;
        next_irValid = 1'b0;
      end
    end
    else if (progMode)
    begin
      next_mode = core_datapath_pkg::MODE_PROG;
      next_progAddr = 9'h000;
      next_progCnt = 4'h0;
      next_irValid = 1'b0;
    end
    else
    begin
      // Fetch overlaps execute; a branch or skip clears the new word
      next_ir = progStore[pc[8:0]];
      next_irValid = 1'b1;
      next_pc = pc + 13'h0001;
      if (irValid)
      begin
        case (ir[13:12])
          2'b00:
          begin
            wrFile = ir[7];
            wrW = ~ir[7];
            case (ir[11:8])
              4'h0:
              begin
                aluBus.op = core_datapath_pkg::ALU_PASSW;
                if (!ir[7])
                begin
                  wrW = 1'b0;
                  if (ir[6:0] == `OP_RETURN || ir[6:0] == `OP_RETFIE)
                  begin
                    next_sp = sp - 3'h1;
                    next_pc = callStack[sp - 3'h1];
                    next_irValid = 1'b0;
                    if (ir[0])
                      next_intCtl[`INTCTL_GLOBAL_EN] = 1'b1;
                  end
                  else if (ir[6:0] == `OP_SLEEP)
                  begin
                    next_status[`ST_POWER_DOWN] = 1'b0;
                    next_status[`ST_TIME_OUT] = 1'b1;
                  end
                  else if (ir[6:0] == `OP_CLRWDT)
                  begin
                    next_status[`ST_POWER_DOWN] = 1'b1;
                    next_status[`ST_TIME_OUT] = 1'b1;
                  end
                end
              end
              4'h1:
              begin
                aluBus.op = core_datapath_pkg::ALU_CLR;
                flagMask = `FLAGS_Z;
              end
              4'h2:
              begin
                aluBus.op = core_datapath_pkg::ALU_SUB;
                flagMask = `FLAGS_CDZ;
              end
              4'h3:
              begin
                aluBus.op = core_datapath_pkg::ALU_DEC;
                flagMask = `FLAGS_Z;
              end
              4'h4:
              begin
                aluBus.op = core_datapath_pkg::ALU_IOR;
                flagMask = `FLAGS_Z;
              end
              4'h5:
              begin
                aluBus.op = core_datapath_pkg::ALU_AND;
                flagMask = `FLAGS_Z;
              end
              4'h6:
              begin
                aluBus.op = core_datapath_pkg::ALU_XOR;
                flagMask = `FLAGS_Z;
              end
              4'h7:
              begin
                aluBus.op = core_datapath_pkg::ALU_ADD;
                flagMask = `FLAGS_CDZ;
              end
              4'h8: flagMask = `FLAGS_Z;
              4'h9:
              begin
                aluBus.op = core_datapath_pkg::ALU_COM;
                flagMask = `FLAGS_Z;
              end
              4'ha:
              begin
                aluBus.op = core_datapath_pkg::ALU_INC;
                flagMask = `FLAGS_Z;
              end
              4'hb: aluBus.op = core_datapath_pkg::ALU_DEC;
              4'hc:
              begin
                aluBus.op = core_datapath_pkg::ALU_RRF;
                flagMask = `FLAGS_C;
              end
              4'hd:
              begin
                aluBus.op = core_datapath_pkg::ALU_RLF;
                flagMask = `FLAGS_C;
              end
              4'he: aluBus.op = core_datapath_pkg::ALU_SWAP;
              default: aluBus.op = core_datapath_pkg::ALU_INC;
            endcase
            // Count-and-skip forms drop the prefetched word on zero
            if ((ir[11:8] == 4'hb || ir[11:8] == 4'hf) && aluBus.zeroOut)
              next_irValid = 1'b0;
          end
          2'b01:
          begin
            case (ir[11:10])
              2'b00:
              begin
                aluBus.op = core_datapath_pkg::ALU_BCLR;
                wrFile = 1'b1;
              end
              2'b01:
              begin
                aluBus.op = core_datapath_pkg::ALU_BSET;
                wrFile = 1'b1;
              end
              2'b10: next_irValid = fileRd[ir[9:7]];
              default: next_irValid = ~fileRd[ir[9:7]];
            endcase
          end
          2'b10:
          begin
            // Call pushes the address of the word after it
            if (!ir[11])
            begin
              stackWe = 1'b1;
              next_sp = sp + 3'h1;
            end
            next_pc = {pc_high_latch[4:3], ir[10:0]};
            next_irValid = 1'b0;
          end
          default:
          begin
            wrW = 1'b1;
            case (ir[11:8])
              4'h4, 4'h5, 4'h6, 4'h7:
              begin
                next_sp = sp - 3'h1;
                next_pc = callStack[sp - 3'h1];
                next_irValid = 1'b0;
              end
              4'h8:
              begin
                aluBus.op = core_datapath_pkg::ALU_IOR;
                flagMask = `FLAGS_Z;
              end
              4'h9:
              begin
                aluBus.op = core_datapath_pkg::ALU_AND;
                flagMask = `FLAGS_Z;
              end
              4'ha:
              begin
                aluBus.op = core_datapath_pkg::ALU_XOR;
                flagMask = `FLAGS_Z;
              end
              4'hb: wrW = 1'b0;
              4'hc, 4'hd:
              begin
                aluBus.op = core_datapath_pkg::ALU_SUB;
                flagMask = `FLAGS_CDZ;
              end
              4'he, 4'hf:
              begin
                aluBus.op = core_datapath_pkg::ALU_ADD;
                flagMask = `FLAGS_CDZ;
              end
              default: aluBus.op = core_datapath_pkg::ALU_PASSF;
            endcase
          end
        endcase
        if (wrW)
          next_w = aluBus.result;
        // Self-referencing indirect write is dropped; flags still land
        if (wrFile && !selfRef)
        begin
          case (ea)
            `ADDR_TIMER_COUNT: next_timer = aluBus.result;
            `ADDR_PC_LOW_BYTE:
            begin
              next_pc = {pc_high_latch, aluBus.result};
              next_irValid = 1'b0;
            end
            `ADDR_ARITH_STATUS:
              next_status = {aluBus.result[7:5], status[4:3], aluBus.result[2:0]};
            `ADDR_INDIRECT_POINTER: next_fsr = aluBus.result;
            `ADDR_PORT_A_PINS: next_portALat = aluBus.result[4:0];
            `ADDR_PORT_B_PINS: next_portBLat = aluBus.result;
            `ADDR_PC_HIGH_LATCH: next_pc_high_latch = aluBus.result[4:0];
            `ADDR_INTERRUPT_CONTROL: next_intCtl = aluBus.result;
            `ADDR_PERIPH_INT_FLAGS: next_pirCmp = aluBus.result[`PIR_CMP_FLAG];
            default: gprWe = (ea >= `ADDR_GPR_FIRST && ea <= `ADDR_GPR_LAST);
          endcase
        end
        // Flags written by the operation override a direct status write
        if (flagMask[2])
          next_status[`ST_ZERO] = aluBus.zeroOut;
        if (flagMask[1])
          next_status[`ST_NIBBLE_CARRY] = aluBus.digitOut;
        if (flagMask[0])
          next_status[`ST_CARRY] = aluBus.carryOut;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mode <= core_datapath_pkg::MODE_RUN;
      pc <= `RST_PC;
      ir <= 14'h0000;
      irValid <= 1'b0;
      w <= `RST_BYTE;
      status <= `RST_STATUS;
      indirect_pointer <= `RST_BYTE;
      pc_high_latch <= `RST_PC_HIGH_LATCH;
      timer <= `RST_BYTE;
      portALat <= 5'h00;
      portBLat <= `RST_BYTE;
      intCtl <= `RST_BYTE;
      pirCmp <= 1'b0;
      sp <= 3'h0;
      progShift <= 14'h0000;
      progCnt <= 4'h0;
      progAddr <= 9'h000;
      progClkPrev <= 1'b0;
    end
    else if (clkEn)
    begin
      mode <= next_mode;
      pc <= next_pc;
      ir <= next_ir;
      irValid <= next_irValid;
      w <= next_w;
      status <= next_status;
      indirect_pointer <= next_fsr;
      pc_high_latch <= next_pc_high_latch;
      timer <= next_timer;
      portALat <= next_portALat;
      portBLat <= next_portBLat;
      intCtl <= next_intCtl;
      pirCmp <= next_pirCmp;
      sp <= next_sp;
      progShift <= next_progShift;
      progCnt <= next_progCnt;
      progAddr <= next_progAddr;
      progClkPrev <= portBIn[6];
    end
  end

  // Memories carry no reset; program store only written by the loader
  always_ff @(posedge clk_sys)
  begin
    if (clkEn)
    begin
      if (pmWe)
        progStore[progAddr] <= {portBIn[7], progShift[13:1]};
      if (gprWe)
        gpr[7'(ea - `ADDR_GPR_FIRST)] <= aluBus.result;
      if (stackWe)
        callStack[sp] <= pc;
    end
  end

  assign portAOut = portALat;
  assign portBOut = portBLat;
  assign accOut = w;
  assign pcOut = pc;

endmodule : core_datapath_sfr_bank0

// ---- verification/core_datapath_sfr_bank0_monitor.sv ----
/*
  Port-level assertions for the bank-0 core: reset, freeze, loader hold, restart.
  Assumes it is bound onto core_datapath_sfr_bank0 with one clock domain.
*/
`timescale 1ns/10ps
module core_datapath_sfr_bank0_monitor (
  input wire logic clk_sys, // Core clock
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic clkEn, // Clock enable
  input wire logic progMode, // Loader mode
  input wire logic [4:0] portAOut, // Port A latch
  input wire logic [7:0] portBOut, // Port B latch
  input wire logic [7:0] accOut, // Accumulator
  input wire logic [12:0] pcOut // Next fetch address
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Outputs still show reset values at the release edge
  a_reset_clears: assert property ($rose(reset_n) |->
    accOut == 8'h00 && pcOut == 13'h0000 && portBOut == 8'h00 && portAOut == 5'h00)
    else $error("outputs not cleared by reset");
  a_acc_frozen: assert property ($changed(accOut) |-> $past(clkEn))
    else $error("accumulator moved while disabled");
  a_pc_frozen: assert property (!clkEn |=> $stable(pcOut))
    else $error("fetch address moved while disabled");
  a_ports_frozen: assert property ((!clkEn) [*3] |-> $stable(portAOut) && $stable(portBOut))
    else $error("port latches moved while disabled");
  // Entry edge is left out: only settled load mode must hold the core
  a_load_holds_acc: assert property (progMode [*3] |-> $stable(accOut))
    else $error("accumulator moved during load");
  a_load_holds_ports: assert property (progMode [*3] |-> $stable(portBOut))
    else $error("port B moved during load");
  a_restart_zero: assert property ($fell(progMode) && clkEn |=> pcOut == 13'h0000)
    else $error("fetch did not restart at zero");
  a_restart_one: assert property (($fell(progMode) && clkEn) ##1 (clkEn && !progMode)
    |=> pcOut == 13'h0001)
    else $error("first fetch not followed by step");
endmodule : core_datapath_sfr_bank0_monitor

bind core_datapath_sfr_bank0 core_datapath_sfr_bank0_monitor u_monitor (
  .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn), .progMode(progMode),
  .portAOut(portAOut), .portBOut(portBOut), .accOut(accOut), .pcOut(pcOut));

// ---- verification/core_datapath_sfr_bank0_tb.sv ----
/*
  Self-checking bench: loads a program serially, then steps it and checks results.
  Assumes the monitor file is compiled alongside for the bound assertions.
*/
`timescale 1ns/10ps
module core_datapath_sfr_bank0_tb;
  logic clk_sys;
  logic reset_n;
  logic clkEn;
  logic progMode;
  logic [4:0] portAIn;
  logic [7:0] portBIn;
  logic [4:0] portAOut;
  logic [7:0] portBOut;
  logic [7:0] accOut;
  logic [12:0] pcOut;
  int err_total;
  int checks_done;
  logic [13:0] prog [0:22];
  logic [7:0] accExp [0:19];

  core_datapath_sfr_bank0 DUT (.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn),
    .progMode(progMode), .portAIn(portAIn), .portBIn(portBIn), .portAOut(portAOut),
    .portBOut(portBOut), .accOut(accOut), .pcOut(pcOut));

  // ----------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Loading and stepping take well under 100 us
  initial
  begin
    #400000;
    err_total++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    results();
  end

  task automatic check(input string what, input logic [12:0] exp, input logic [12:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Serial loader: data settles while the loader clock is low, LSB first
  task automatic load_word(input logic [13:0] word);
    for (int b = 0; b < 14; b++)
    begin
      portBIn[7] = word[b];
      portBIn[6] = 1'b0;
      @(posedge clk_sys) #1;
      portBIn[6] = 1'b1;
      @(posedge clk_sys) #1;
    end
  endtask : load_word

  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    reset_n = 1'b0;
    clkEn = 1'b1;
    progMode = 1'b0;
    portAIn = 5'h0a;
    portBIn = 8'h00;
    err_total = 0;
    checks_done = 0;
    // Literal, indirect store/load, pointer at zero, flags, latched jump, goto self
    // Bank bits are never written, so direct access always lands in bank 0
    prog = '{14'h3055, 14'h0086, 14'h3020, 14'h0084, 14'h30a5, 14'h0080, 14'h0100,
      14'h0820, 14'h0184, 14'h0800, 14'h30ff, 14'h3e01, 14'h0803, 14'h3001,
      14'h3c00, 14'h0803, 14'h0085, 14'h3002, 14'h008a, 14'h3016, 14'h0082, 14'h3077,
      14'h2816};
    accExp = '{8'h55, 8'h55, 8'h20, 8'h20, 8'ha5, 8'ha5, 8'h00, 8'ha5, 8'ha5,
      8'h00, 8'hff, 8'h00, 8'h1f, 8'h01, 8'hff, 8'h18, 8'h18, 8'h02, 8'h02, 8'h16};
    repeat (12) @(posedge clk_sys);
    #1;
    check("accOut in reset", 13'h0000, {5'h00, accOut});
    reset_n = 1'b1;
    @(posedge clk_sys) #1;
    progMode = 1'b1;
    @(posedge clk_sys) #1;
    foreach (prog[i]) load_word(prog[i]);
    progMode = 1'b0;
    portBIn = 8'h00;
    // Fetch address is left over from before the load, so restart is checked edge by edge
    @(posedge clk_sys) #1;
    check("pcOut restart", 13'h0000, pcOut);
    @(posedge clk_sys) #1;
    check("pcOut first fetch", 13'h0001, pcOut);
    // One instruction retires per edge; accumulator shows its result
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clk_sys) #1;
      check("accOut", {5'h00, accExp[i]}, {5'h00, accOut});
      check("pcOut", 13'(i + 2), pcOut);
    end
    check("portBOut", {5'h00, 8'h55}, {5'h00, portBOut});
    check("portAOut", 13'h0018, {8'h00, portAOut});
    // Low byte write takes upper bits from the latch; the word behind it must not run
    @(posedge clk_sys) #1;
    check("pcOut low byte write", 13'h0216, pcOut);
    @(posedge clk_sys) #1;
    check("accOut flushed slot", 13'h0016, {5'h00, accOut});
    check("pcOut after jump", 13'h0217, pcOut);
    // Taken goto to itself: the flushed slot makes the loop two cycles long
    @(posedge clk_sys) #1;
    check("pcOut branch", 13'h0016, pcOut);
    @(posedge clk_sys) #1;
    check("pcOut refetch", 13'h0017, pcOut);
    @(posedge clk_sys) #1;
    check("pcOut branch again", 13'h0016, pcOut);
    clkEn = 1'b0;
    repeat (3) @(posedge clk_sys) #1;
    check("pcOut frozen", 13'h0016, pcOut);
    clkEn = 1'b1;
    @(posedge clk_sys) #1;
    check("accOut held", 13'h0016, {5'h00, accOut});
    results();
  end
endmodule : core_datapath_sfr_bank0_tb
